// ===== src/flpw_consts.svh
// Constants for the four-level page walker: field positions, widths and offsets
`ifndef FLPW_CONSTS_SVH
`define FLPW_CONSTS_SVH

// Wishbone register byte offsets
`define FLPW_OFS_CTRL    8'h00
`define FLPW_OFS_LIN_LO  8'h04
`define FLPW_OFS_LIN_HI  8'h08
`define FLPW_OFS_ROOT_LO 8'h0C
`define FLPW_OFS_ROOT_HI 8'h10
`define FLPW_OFS_STAT    8'h14
`define FLPW_OFS_PHYS_LO 8'h18
`define FLPW_OFS_PHYS_HI 8'h1C
`define FLPW_OFS_ATTR    8'h20

// Control register bits
`define FLPW_CTRL_AXE    0
`define FLPW_CTRL_SXE    1
`define FLPW_CTRL_LONG   2
`define FLPW_CTRL_XDE    3
`define FLPW_CTRL_START  4

// Entry flag positions, identical at every level
`define FLPW_E_PRESENT   0
`define FLPW_E_WRITE     1
`define FLPW_E_USER      2
`define FLPW_E_WT        3
`define FLPW_E_CD        4
`define FLPW_E_ACC       5
`define FLPW_E_DIRTY     6
`define FLPW_E_LARGE     7
`define FLPW_E_XD        63

// Linear address split
`define FLPW_LIN_W       48
`define FLPW_IDX_W       9
`define FLPW_OFS4K_W     12
`define FLPW_OFS2M_W     21

// Reserved ranges checked in long mode
`define FLPW_RSV_HI      51
`define FLPW_RSV_LO      40
`define FLPW_RSV2M_HI    20
`define FLPW_RSV2M_LO    13

// Reset values
`define FLPW_CTRL_RST    5'h00
`endif

// ===== src/flpw_pkg.sv
// Types for the four-level page walker
package flpw_pkg;
	// Walk sequencer states
	typedef enum logic [2:0]
	{
		FLPW_IDLE,
		FLPW_FETCH,
		FLPW_WAIT,
		FLPW_DONE
	} flpw_state_t;

	// Fault causes reported in status
	typedef enum logic [1:0]
	{
		FLPW_FLT_NONE,
		FLPW_FLT_GP,
		FLPW_FLT_NOTPRESENT,
		FLPW_FLT_RESERVED
	} flpw_fault_t;
endpackage : flpw_pkg

// ===== src/flpw_walker.sv
// Four-level linear-to-physical page walker with a Wishbone register slave
// Notes on behaviour
// - Long mode without address extension gives protection fault
// - 48-bit linear in, 40-bit physical out
// - Physical width is a parameter up to 52
// - Long mode walks up to four levels
// - Level4 map table only used in long mode
// - Pointer table: 512 entries, nine-bit index
// - Directory and page tables: 512 entries, nine bits
// - Upper 16 linear bits ignored
// - Large page flag picks size; size extension ignored
// - Index bits 47:39,38:30,29:21,20:12; offset 11:0
// - Each entry gives next base or page base
// - 2-MByte page: directory base plus bits 20:0
// - Entries are read as 64 bits
// - Common flags share positions at all levels
// - 40-bit physical means 28-bit base field
// - Bits 62:52 never affect translation
// - Bit 63 execute-disable, else reserved
// - Execute-disable only with extended 64-bit entries
// - Legacy extended mode uses same entry formats
// - Large page flag is directory entry bit 7
// - Accessed and dirty at bits 5, 6
// - Long mode reserved checks 63, 51:40, 20:13
// - Reserved bits in directory/page entries page-fault; checked in long mode only
`timescale 1ns/1ps
`include "flpw_consts.svh"

module flpw_walker #(
	parameter int PA_W = 40                        // Physical address width, at most 52
)(
	input  wire logic        clk_sys,              // Core clock, 20 MHz
	input  wire logic        rst,                  // Synchronous reset, active high
	// Wishbone classic slave
	input  wire logic        wb_cyc_i,             // Bus cycle
	input  wire logic        wb_stb_i,             // Strobe
	input  wire logic        wb_we_i,              // Write enable
	input  wire logic [7:0]  wb_adr_i,             // Byte address
	input  wire logic [3:0]  wb_sel_i,             // Byte lanes
	input  wire logic [31:0] wb_dat_i,             // Write data
	output logic      [31:0] wb_dat_o,             // Read data
	output logic             wb_ack_o,             // Acknowledge
	// Table memory read port
	output logic             mem_req,              // Fetch request, held until mem_ack
	output logic      [PA_W-1:0] mem_addr,         // Entry byte address
	input  wire logic        mem_ack,              // Entry data valid, one cycle
	input  wire logic [63:0] mem_data,             // Entry read
	// Exception outputs
	output logic             gp_fault,             // General protection fault, level
	output logic             page_fault            // Page fault exception, level
);
	localparam int BASE_W = PA_W - `FLPW_OFS4K_W;  // 28 bits when PA_W is 40

	// Control and translation state
	logic [4:0]            ctrl;                   // AXE, SXE, LONG, XDE
	logic [47:0]           lin;                    // Linear address, upper 16 never stored
	logic [PA_W-1:0]       root;                   // Top table base
	logic [PA_W-1:0]       base;                   // Current table base
	logic [1:0]            level;                  // 3 = level4 map, 0 = page table
	logic [PA_W-1:0]       phys;                   // Result
	logic [7:0]            attr;                   // Final flags plus xd and large
	logic                  busy;
	logic                  done;
	flpw_pkg::flpw_fault_t fault;
	flpw_pkg::flpw_state_t state;
	logic                  ack_q;

	// Field decode of the fetched entry
	wire                   e_present = mem_data[`FLPW_E_PRESENT];
	wire                   e_large   = mem_data[`FLPW_E_LARGE];
	wire                   long_mode = ctrl[`FLPW_CTRL_LONG];
	wire                   xd_on     = ctrl[`FLPW_CTRL_XDE] & ctrl[`FLPW_CTRL_AXE];
	// Base field, bits above PA_W and 62:52 are not looked at
	wire [BASE_W-1:0]      e_base    = mem_data[PA_W-1:`FLPW_OFS4K_W];
	wire                   is_dir    = (level == 2'd1);
	wire                   is_leaf   = (level == 2'd0) | (is_dir & e_large);
	// Reserved check: 63 when xd off, 51:40, plus 20:13 on a large directory entry
	wire                   rsv_hit   = long_mode & (
		(~xd_on & mem_data[`FLPW_E_XD]) |
		(|mem_data[`FLPW_RSV_HI:`FLPW_RSV_LO]) |
		(is_dir & e_large & (|mem_data[`FLPW_RSV2M_HI:`FLPW_RSV2M_LO])));

	// Index for the current level: 47:39, 38:30, 29:21, 20:12
	function automatic logic [8:0] lvl_index(input logic [47:0] a, input logic [1:0] l);
		logic [5:0] sh;
		sh = 6'd12 + 6'd9 * {4'h0, l};
		lvl_index = 9'((a >> sh) & 48'h0000_0000_01FF);
	endfunction : lvl_index

	// Fetch address: base, index, three zeros
	assign mem_addr = {base[PA_W-1:`FLPW_OFS4K_W], lvl_index(lin, level), 3'h0};
	assign mem_req  = (state == flpw_pkg::FLPW_WAIT);
	assign gp_fault   = (fault == flpw_pkg::FLPW_FLT_GP);
	assign page_fault = (fault == flpw_pkg::FLPW_FLT_NOTPRESENT) | (fault == flpw_pkg::FLPW_FLT_RESERVED);

	// Register decode
	wire                   wb_hit   = wb_cyc_i & wb_stb_i & ~ack_q;
	wire                   wr_ctrl  = wb_hit & wb_we_i & (wb_adr_i == `FLPW_OFS_CTRL) & wb_sel_i[0];
	wire                   start    = wr_ctrl & wb_dat_i[`FLPW_CTRL_START] & ~busy;
	// Entering long mode without address extension is refused
	wire                   bad_mode = wb_dat_i[`FLPW_CTRL_LONG] & ~wb_dat_i[`FLPW_CTRL_AXE];

	// Read mux
	logic [31:0] rd;
	always_comb
	begin
		case (wb_adr_i)
			`FLPW_OFS_CTRL:    rd = {27'h0, 1'b0, ctrl[3:0]};
			`FLPW_OFS_LIN_LO:  rd = lin[31:0];
			`FLPW_OFS_LIN_HI:  rd = {16'h0000, lin[47:32]};
			`FLPW_OFS_ROOT_LO: rd = 32'(root);
			`FLPW_OFS_ROOT_HI: rd = 32'(root >> 32);
			`FLPW_OFS_STAT:    rd = {26'h0, fault, done, busy, 2'h0};
			`FLPW_OFS_PHYS_LO: rd = 32'(phys);
			`FLPW_OFS_PHYS_HI: rd = 32'(phys >> 32);
			`FLPW_OFS_ATTR:    rd = {24'h0, attr};
			default:           rd = 32'h0000_0000;    // Unmapped reads zero
		endcase
	end

	// Bus answer: one wait state, ack for one cycle
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ack_q    <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			ack_q    <= wb_hit;
			wb_dat_o <= rd;
		end
	end
	assign wb_ack_o = ack_q;

	// Software-written registers; writes ignored while a walk runs
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ctrl <= `FLPW_CTRL_RST;
			lin  <= 48'h0000_0000_0000;
			root <= '0;
		end
		else if (wb_hit & wb_we_i & ~busy)
		begin
			if ((wb_adr_i == `FLPW_OFS_CTRL) & wb_sel_i[0])
			begin
				// Long mode bit is dropped when extension is off
				ctrl <= {1'b0, wb_dat_i[3], wb_dat_i[2] & wb_dat_i[0], wb_dat_i[1:0]};
			end
			if (wb_adr_i == `FLPW_OFS_LIN_LO)
				lin[31:0] <= wb_dat_i;
			if (wb_adr_i == `FLPW_OFS_LIN_HI)
				lin[47:32] <= wb_dat_i[15:0];
			if (wb_adr_i == `FLPW_OFS_ROOT_LO)
				root <= PA_W'({64'(root) >> 32, wb_dat_i} );
			if (wb_adr_i == `FLPW_OFS_ROOT_HI)
				root <= PA_W'({wb_dat_i, 32'(root)});
		end
	end

	// Walk sequencer
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state <= flpw_pkg::FLPW_IDLE;
			level <= 2'd3;
			base  <= '0;
			phys  <= '0;
			attr  <= 8'h00;
			busy  <= 1'b0;
			done  <= 1'b0;
			fault <= flpw_pkg::FLPW_FLT_NONE;
		end
		else
		begin
			case (state)
				flpw_pkg::FLPW_IDLE:
				begin
					if (start & bad_mode)
					begin
						fault <= flpw_pkg::FLPW_FLT_GP;
						done  <= 1'b1;
					end
					else if (start)
					begin
						// Level4 map only in long mode; else start at pointer table
						level <= (wb_dat_i[`FLPW_CTRL_LONG] & wb_dat_i[`FLPW_CTRL_AXE]) ? 2'd3 : 2'd2;
						base  <= root;
						busy  <= 1'b1;
						done  <= 1'b0;
						fault <= flpw_pkg::FLPW_FLT_NONE;
						state <= flpw_pkg::FLPW_WAIT;
					end
				end
				flpw_pkg::FLPW_WAIT:
				begin
					if (mem_ack)
					begin
						if (~e_present)
						begin
							fault <= flpw_pkg::FLPW_FLT_NOTPRESENT;
							state <= flpw_pkg::FLPW_DONE;
						end
						else if (rsv_hit)
						begin
							fault <= flpw_pkg::FLPW_FLT_RESERVED;
							state <= flpw_pkg::FLPW_DONE;
						end
						else if (is_leaf)
						begin
							// Page base plus offset, 4K or 2M
							phys  <= (level == 2'd0) ?
								{e_base, lin[11:0]} :
								{e_base[BASE_W-1:9], lin[20:0]};
							// Accessed bit 5 reported; attr bit 6 holds the large flag, not dirty
							attr  <= {xd_on & mem_data[`FLPW_E_XD], e_large, mem_data[5:0]};
							state <= flpw_pkg::FLPW_DONE;
						end
						else
						begin
							base  <= {e_base, 12'h000};
							level <= level - 2'd1;
						end
					end
				end
				flpw_pkg::FLPW_DONE:
				begin
					busy  <= 1'b0;
					done  <= 1'b1;
					state <= flpw_pkg::FLPW_IDLE;
				end
				default:
					state <= flpw_pkg::FLPW_IDLE;
			endcase
		end
	end

	// Fault checks
	a_gp_on_bad_mode: assert property (@(posedge clk_sys) disable iff (rst)
		(state == flpw_pkg::FLPW_IDLE) && start && bad_mode |=> gp_fault && !busy)
		else $error("mode entry without extension did not fault");
	a_absent_faults: assert property (@(posedge clk_sys) disable iff (rst)
		(state == flpw_pkg::FLPW_WAIT) && mem_ack && !e_present |=> page_fault ##1 done && !busy)
		else $error("absent entry did not page fault");
	a_rsv_faults: assert property (@(posedge clk_sys) disable iff (rst)
		(state == flpw_pkg::FLPW_WAIT) && mem_ack && e_present && long_mode &&
		(|mem_data[51:40]) |=> page_fault)
		else $error("reserved bits not faulted");
	a_leaf_offset: assert property (@(posedge clk_sys) disable iff (rst)
		(state == flpw_pkg::FLPW_WAIT) && mem_ack && e_present && !rsv_hit && level == 2'd0
		|=> phys[11:0] == lin[11:0])
		else $error("page offset wrong");
	a_large_offset: assert property (@(posedge clk_sys) disable iff (rst)
		(state == flpw_pkg::FLPW_WAIT) && mem_ack && e_present && !rsv_hit && is_dir && e_large
		|=> phys[20:0] == lin[20:0])
		else $error("large page offset wrong");
	a_addr_align: assert property (@(posedge clk_sys) disable iff (rst)
		mem_req |-> mem_addr[2:0] == 3'h0 && mem_addr[11:3] == lvl_index(lin, level))
		else $error("fetch address misformed");
	a_no_l4_short: assert property (@(posedge clk_sys) disable iff (rst)
		(state == flpw_pkg::FLPW_IDLE) && start && !bad_mode && !wb_dat_i[`FLPW_CTRL_LONG]
		|=> level == 2'd2)
		else $error("level4 used outside long mode");
	a_level_step: assert property (@(posedge clk_sys) disable iff (rst)
		(state == flpw_pkg::FLPW_WAIT) && mem_ack && e_present && !rsv_hit && !is_leaf
		|=> level == $past(level) - 2'd1 && mem_req)
		else $error("walk did not descend");
	a_ack_pulse: assert property (@(posedge clk_sys) disable iff (rst)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");

	// Entry checks below are built from these steps of one fetch.
	// The sequences carry no clock of their own; each property supplies it.

	// An entry arrived, is present and carries no reserved bits
	sequence s_entry_used;
		(state == flpw_pkg::FLPW_WAIT) && mem_ack && e_present && !rsv_hit;
	endsequence

	// The used entry ends the walk
	sequence s_leaf_used;
		s_entry_used ##0 is_leaf;
	endsequence

	// The used entry points to a further table
	sequence s_table_used;
		s_entry_used ##0 !is_leaf;
	endsequence

	// The used entry is a directory entry that maps a large page
	sequence s_large_used;
		s_leaf_used ##0 is_dir;
	endsequence

	// The used entry is a page table entry
	sequence s_small_used;
		s_leaf_used ##0 (level == 2'd0);
	endsequence

	// Result checks: the used entry fields land in the result registers, or in the next table base

	// Flag bits 5:0 are copied bit for bit from the leaf entry at either leaf level
	a_leaf_flags: assert property (@(posedge clk_sys) disable iff (rst)
		s_leaf_used |=> attr[5:0] == $past(mem_data[5:0]))
		else $error("leaf flags not reported");

	// The execute-disable bit only counts when the feature is on
	a_leaf_xd: assert property (@(posedge clk_sys) disable iff (rst)
		s_leaf_used |=> attr[7] == (xd_on && $past(mem_data[`FLPW_E_XD])))
		else $error("execute-disable report wrong");

	// A large page keeps only the upper base bits of the directory entry
	a_large_base: assert property (@(posedge clk_sys) disable iff (rst)
		s_large_used |=> attr[6] && phys[PA_W-1:21] == $past(e_base[BASE_W-1:9]))
		else $error("large page base wrong");

	// A small page takes the whole base field of the page table entry
	a_page_base: assert property (@(posedge clk_sys) disable iff (rst)
		s_small_used |=> phys[PA_W-1:12] == $past(e_base))
		else $error("page base wrong");

	// A table entry gives the base of the next level
	a_table_base: assert property (@(posedge clk_sys) disable iff (rst)
		s_table_used |=> base[PA_W-1:12] == $past(e_base))
		else $error("next table base wrong");

	// Memory side: the request must not wander while the memory is slow

	// Address stands until the answer; a moving address would fetch a wrong entry
	a_req_hold: assert property (@(posedge clk_sys) disable iff (rst)
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("fetch request moved before answer");

	// A long mode start goes straight to the level4 map fetch
	a_long_start: assert property (@(posedge clk_sys) disable iff (rst)
		(state == flpw_pkg::FLPW_IDLE) && start && wb_dat_i[`FLPW_CTRL_LONG] && wb_dat_i[`FLPW_CTRL_AXE]
		|=> level == 2'd3 && mem_req)
		else $error("long walk did not start at level4");

	// The end state lasts one cycle and leaves busy clear and done set
	a_done_step: assert property (@(posedge clk_sys) disable iff (rst)
		(state == flpw_pkg::FLPW_DONE) |=> !busy && done && (state == flpw_pkg::FLPW_IDLE))
		else $error("walk did not finish cleanly");

	// Fault and mode checks

	// A refused mode entry stays reported until the next start
	a_gp_holds: assert property (@(posedge clk_sys) disable iff (rst)
		gp_fault && !start |=> gp_fault)
		else $error("protection fault dropped early");

	// Long mode can never be stored without the extension bit
	a_long_needs_ext: assert property (@(posedge clk_sys) disable iff (rst)
		ctrl[`FLPW_CTRL_LONG] |-> ctrl[`FLPW_CTRL_AXE])
		else $error("long mode stored without extension");

	// Large page directory entries also check the low reserved field
	a_rsv_large: assert property (@(posedge clk_sys) disable iff (rst)
		(state == flpw_pkg::FLPW_WAIT) && mem_ack && e_present && long_mode && is_dir && e_large &&
		(|mem_data[`FLPW_RSV2M_HI:`FLPW_RSV2M_LO]) |=> page_fault)
		else $error("large page reserved bits not faulted");

	// Bit 63 is reserved while execute-disable is off
	a_rsv_xd: assert property (@(posedge clk_sys) disable iff (rst)
		(state == flpw_pkg::FLPW_WAIT) && mem_ack && e_present && long_mode && !xd_on &&
		mem_data[`FLPW_E_XD] |=> page_fault)
		else $error("reserved bit 63 not faulted");

	// Bus side: every new request is answered in the next cycle
	a_ack_follow: assert property (@(posedge clk_sys) disable iff (rst)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered");
endmodule : flpw_walker

// ===== tb/flpw_mem_model.sv
// Table memory model that answers walker entry fetches
`timescale 1ns/1ps

module flpw_mem_model (
	input  wire logic        clk_sys,   // Core clock
	input  wire logic        rst,       // Sync reset
	input  wire logic        mem_req,   // Fetch request
	input  wire logic [39:0] mem_addr,  // Entry byte address
	output logic             mem_ack,   // One-cycle answer
	output logic      [63:0] mem_data   // Entry word
);
	logic [63:0] mem [logic [39:0]];    // Sparse tables, unmapped reads as absent entry
	int          lat = 1;               // Answer delay, set by the bench
	int          cnt = 0;               // Wait counter

	initial mem_ack = 1'b0;
	initial mem_data = 64'h0000_0000_0000_0000;

	// Answer after lat cycles; data churns otherwise so a stale word is never trusted
	always @(posedge clk_sys)
	begin
		mem_ack <= 1'b0;
		mem_data <= ~mem_data;
		if (rst)
			cnt <= 0;
		else if (mem_req && !mem_ack)
		begin
			if (cnt >= lat)
			begin
				mem_ack <= 1'b1;
				mem_data <= mem.exists(mem_addr) ? mem[mem_addr] : 64'h0000_0000_0000_0000;
				cnt <= 0;
			end
			else
				cnt <= cnt + 1;
		end
	end
endmodule : flpw_mem_model

// ===== tb/test_four_level_page_walker.sv
// Register-level bench for the page walker
`timescale 1ns/1ps
`include "flpw_consts.svh"

module test_four_level_page_walker;
	logic        clk_sys = 1'b0;  // 20 MHz clock
	logic        rst     = 1'b1;  // Held 12 cycles
	logic        cyc     = 1'b0;  // Bus cycle
	logic        stb     = 1'b0;  // Strobe
	logic        we      = 1'b0;  // Write
	logic [7:0]  adr     = 8'h00; // Address
	logic [3:0]  sel     = 4'hf;  // Lanes
	logic [31:0] dat_i   = 32'h0000_0000;
	logic [31:0] dat_o;
	logic        ack, mem_req, mem_ack, gp, pf;
	logic [39:0] mem_addr;
	logic [63:0] mem_data;
	int          err_count = 0;
	int          checks = 0;
	logic [63:0] ent = 64'h7ff0_0000_0000_0003; // Present, writable, software bits set
	logic [63:0] page = 64'h0000_00ab_cdef_5000;
	logic [31:0] q;

	always #25 clk_sys = ~clk_sys;

	flpw_walker #(.PA_W(40)) flpw_walker_inst (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_data(mem_data),
		.gp_fault(gp), .page_fault(pf));
	flpw_mem_model flpw_mem_model_inst (.clk_sys(clk_sys), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_ack(mem_ack), .mem_data(mem_data));

	// Compare one result, count it
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Classic single cycle; held until ack is sampled high
	task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_i <= d;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			err_count++;
			$display("mismatch at %0t: bus answer timed out", $time);
		end
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_sys);
	endtask : wb

	// Launch one walk, wait for idle, check fault and address
	task walk(input logic [31:0] ctrl, input logic [1:0] flt, input logic [63:0] ph);
		int n;
		wb(`FLPW_OFS_LIN_LO, 1'b1, 32'h8060_4123);
		wb(`FLPW_OFS_LIN_HI, 1'b1, 32'hffff_0080); // Upper junk must be ignored
		wb(`FLPW_OFS_CTRL, 1'b1, ctrl);
		n = 0;
		do
		begin
			wb(`FLPW_OFS_STAT, 1'b0, 32'h0000_0000);
			n++;
		end
		while (q[2] !== 1'b0 && n < 40);
		chk({30'h0, q[5:4]}, {30'h0, flt});
		chk({31'h0, gp}, {31'h0, flt == 2'd1});
		chk({31'h0, pf}, {31'h0, flt[1]});
		if (flt == 2'd0)
		begin
			wb(`FLPW_OFS_PHYS_LO, 1'b0, 32'h0000_0000);
			chk(q, ph[31:0]);
			wb(`FLPW_OFS_PHYS_HI, 1'b0, 32'h0000_0000);
			chk(q, ph[63:32]);
		end
	endtask : walk

	task close_out;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out

	// Watchdog well beyond the expected run
	initial
	begin
		#2_000_000;
		err_count++;
		close_out;
	end

	// Main sequence
	initial
	begin
		flpw_mem_model_inst.mem[40'h00_0000_1008] = ent | 64'h0000_0000_0000_2000;
		flpw_mem_model_inst.mem[40'h00_0000_2010] = ent | 64'h0000_0000_0000_3000;
		flpw_mem_model_inst.mem[40'h00_0000_3018] = ent | 64'h0000_0000_0000_4000;
		flpw_mem_model_inst.mem[40'h00_0000_4020] = ent | page;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		wb(`FLPW_OFS_ROOT_LO, 1'b1, 32'h0000_1000);
		wb(`FLPW_OFS_ROOT_HI, 1'b1, 32'h0000_0000);
		walk(32'h0000_0015, 2'd0, page | 64'h123);
		wb(`FLPW_OFS_ATTR, 1'b0, 32'h0000_0000);
		chk(q, 32'h0000_0003);
		flpw_mem_model_inst.lat = 3;
		walk(32'h0000_0017, 2'd0, page | 64'h123);
		wb(`FLPW_OFS_ROOT_LO, 1'b1, 32'h0000_2000);
		walk(32'h0000_0011, 2'd0, page | 64'h123);
		walk(32'h0000_0014, 2'd1, 64'h0);
		wb(`FLPW_OFS_ROOT_LO, 1'b1, 32'h0000_1000);
		flpw_mem_model_inst.mem[40'h00_0000_3018] = ent | 64'h0000_0000_8000_0080;
		walk(32'h0000_0015, 2'd0, 64'h0000_0000_8000_4123);
		walk(32'h0000_0017, 2'd0, 64'h0000_0000_8000_4123);
		wb(`FLPW_OFS_ATTR, 1'b0, 32'h0000_0000);
		chk(q, 32'h0000_0043);
		flpw_mem_model_inst.mem[40'h00_0000_3018] = ent | 64'h0000_0000_0000_4000;
		flpw_mem_model_inst.mem[40'h00_0000_4020] = ent | page | 64'h0000_0100_0000_0000;
		walk(32'h0000_0015, 2'd3, 64'h0);
		flpw_mem_model_inst.mem[40'h00_0000_4020] = page;
		walk(32'h0000_0015, 2'd2, 64'h0);
		wb(8'h40, 1'b0, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		close_out;
	end
endmodule : test_four_level_page_walker
